// ---- dv/slbc_checker_monitor.sv ----
// self-test checker assertions
module slbc_mon (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire link_lock_i,
  input wire remote_selftest_ack_i,
  input wire frame_valid_i,
  input wire [34:0] frame_data_i,
  input wire selftest_active_o,
  input wire link_normal_o,
  input wire pass_o,
  input wire [7:0] fwd_err_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic chk_q;
  wire act = selftest_active_o;
  wire bad = frame_valid_i && |frame_data_i;
  // checking once locked and the far end answered
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) chk_q <= 1'h0;
    else chk_q <= act && (chk_q || link_lock_i && remote_selftest_ack_i);
  end
  mode_inv_a: assert property (link_normal_o == !act) else $error("mode");
  new_clear_a: assert property ($rose(act) |-> !pass_o) else $error("clear");
  chk_start_a: assert property ($rose(chk_q) |-> pass_o) else $error("start");
  err_pulse_a: assert property (chk_q && act && bad |=> !pass_o) else $error("pulse");
  pulse_end_a: assert property (chk_q && !bad |=> pass_o || !act) else $error("stuck");
  hold_fail_a: assert property (!act && !pass_o |=> !pass_o) else $error("fail");
  hold_pass_a: assert property (!act && pass_o |=> pass_o || act) else $error("pass");
  err_count_a: assert property (chk_q && act && bad && fwd_err_count_o != 8'hFF
    |=> fwd_err_count_o == $past(fwd_err_count_o) + 8'h01) else $error("count");
  cover property (chk_q && bad);
  cover property ($fell(act) && pass_o);
  cover property ($fell(act) && !pass_o);
endmodule
bind slbc_checker slbc_mon i_mon (.*);

// ---- dv/slbc_far.sv ----
// far-end serializer model
module slbc_far (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire req_i,
  input wire inj_i,
  output logic ack_o,
  output logic fv_o,
  output logic [34:0] fd_o,
  input wire crc_inj_i,
  output logic [7:0] crc_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bc_lock_q;
  // back-channel link detect one cycle after entering self-test
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) bc_lock_q <= 1'h0;
    else bc_lock_q <= ack_o;
  end
  // cleared on entering self-test, saturating 8-bit count
  // counts only in self-test and keeps the last run afterwards
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) crc_cnt_o <= 8'h00;
    else if (req_i && !ack_o) crc_cnt_o <= 8'h00;
    else if (ack_o && bc_lock_q && crc_inj_i && crc_cnt_o != 8'hFF)
      crc_cnt_o <= crc_cnt_o + 8'h01;
  end
  // wakes on request, sends zero frames
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) {ack_o, fv_o} <= 2'h0;
    else {ack_o, fv_o} <= {req_i, ack_o && !fv_o};
  end
  // idle data is noise so a stale zero never looks like a frame
  always @(posedge clk_sys_i) fd_o <= ack_o && !fv_o ? {inj_i, 33'h0, inj_i} : {$urandom, 3'h7};
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the self-test checker
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, rstn_i = 0, selftest_enable_pin_i = 0, selftest_enable_cfg_i = 0;
  logic selftest_clock_select_pin_i = 0, selftest_clock_select_cfg_i = 0, inj = 0;
  logic selftest_strap_high_i = 0, link_lock_i = 0, crc_inj = 0;
  wire [7:0] crc_cnt;
  wire remote_selftest_ack_i, frame_valid_i, bc_selftest_req_o, bc_use_internal_clock_o;
  wire selftest_active_o, link_normal_o, lock_o, pass_o;
  wire [34:0] frame_data_i;
  wire [7:0] fwd_err_count_o;
  int n_errors = 0, n_checks = 0;
  slbc_checker i_slbc_checker (.*);
  slbc_far i_slbc_far (.clk_sys_i, .rstn_i, .req_i(bc_selftest_req_o), .inj_i(inj),
    .ack_o(remote_selftest_ack_i), .fv_o(frame_valid_i), .fd_o(frame_data_i),
    .crc_inj_i(crc_inj), .crc_cnt_o(crc_cnt));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("%0d checks %0d errors", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // mode 0 clean, 1 every frame errored except in the last 4 cycles, 2 random errors
  task automatic run(bit cfg, int cyc, mode);
    int n, n_crc;
    bit e, seen, pin;
    n = 0;
    n_crc = 0;
    seen = 0;
    pin = 0;
    @(posedge clk_sys_i);
    // strap high in the same cycle the test is enabled
    {link_lock_i, selftest_strap_high_i, selftest_clock_select_cfg_i} <= {2'h3, cfg};
    selftest_enable_cfg_i <= cfg;
    selftest_enable_pin_i <= !cfg;
    // duration is how long the enable stays up
    for (int k = 0; k < cyc; k++) begin
      @(posedge clk_sys_i);
      e = frame_valid_i && |frame_data_i;
      seen |= frame_valid_i;
      n += e;
      n_crc += crc_inj;
      inj <= k + 4 < cyc && (mode > 1 ? $urandom_range(5) == 0 : mode == 1);
      crc_inj <= k >= 8 && k + 4 < cyc && $urandom_range(5) == 0;
      pin = 1'($urandom_range(1));
      selftest_clock_select_pin_i <= pin;
      @(negedge clk_sys_i);
      #2;
      // errored frame shows low in the clock-low half
      if (seen) chk(pass_o, !e);
      if (seen) chk(bc_selftest_req_o, 8'h01);
    end
    @(posedge clk_sys_i);
    {selftest_enable_pin_i, selftest_enable_cfg_i} <= 2'h0;
    repeat (6) @(negedge clk_sys_i);
    chk(pass_o, n == 0);
    chk(link_normal_o, 8'h01);
    chk(selftest_active_o, 8'h00);
    chk(bc_selftest_req_o, 8'h00);
    chk(bc_use_internal_clock_o, cfg | pin);
    chk(lock_o, link_lock_i);
    chk(fwd_err_count_o, n > 255 ? 255 : n);
    chk(crc_cnt, n_crc > 255 ? 255 : n_crc);
    $display("test end, %0d errored frames", n);
  endtask
  initial begin
    void'($urandom(32'hD213));
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    run(1'h0, 700, 1);
    @(posedge clk_sys_i);
    rstn_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    @(negedge clk_sys_i);
    chk(pass_o, 8'h01);
    run(1'h0, 100 + $urandom_range(200), 0);
    run(1'h1, 300, 2);
    tally_and_finish;
  end
  initial begin
    #30us;
    n_errors++;
    tally_and_finish;
  end
endmodule

// ---- hw/slbc_checker.v ----
// self-test checker: requests far-end pattern, checks frames, holds pass/fail
// Contract
// (RL1) test starts on enable pin or config bit
// (RL2) clock from pixel clock or oscillator select
// (RL3) send self-test enable over back channel
// (RL4) far end wakes, sends all-zeros pattern
// (RL5) after lock, pass goes high, checking begins
// (RL6) one result pulse per errored 35-bit frame
// (RL7) error pulse is low for half period
// (RL8) enable low stops; hold high or low
// (RL9) result held until new test or reset
// (RL10) host sets duration by enable length
// (RL11) lock output valid throughout self-test
// (RL12) enable low returns link to normal
// (RL13) board straps gpio zero high, others low
// (RL14) forward errors counted, readable at 0x25; here only on fwd_err_count_o, no address decode
// (RL15) far end checks back-channel CRC after lock
// (RL16) far end counts CRC errors, 8-bit
// (RL17) far end CRC count kept per run
// (RL18) synchronise enable and clock-select pins
`include "slbc_defines.vh"
module slbc_checker (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire selftest_enable_pin_i,
  input wire selftest_enable_cfg_i,
  input wire selftest_clock_select_pin_i,
  input wire selftest_clock_select_cfg_i,
  input wire selftest_strap_high_i,
  input wire link_lock_i,
  input wire remote_selftest_ack_i,
  input wire frame_valid_i,
  input wire [`SLBC_FRAME_BITS-1:0] frame_data_i,
  output wire bc_selftest_req_o,
  output wire bc_use_internal_clock_o,
  output wire selftest_active_o,
  output wire link_normal_o,
  output wire lock_o,
  output wire pass_o,
  output wire [`SLBC_ERRCNT_BITS-1:0] fwd_err_count_o
);
  // one-hot states; a corrupted code falls back to idle through the default
  // idle: no test since reset, pass shows its reset level
  // wait: request sent, waiting for lock and the far end's answer
  // check: every valid frame is compared against all zeros
  // done: enable dropped, final result held until the next start
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_CHECK = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  wire en_pin_s;
  wire csel_pin_s;
  // (RL18) synchronise pins
  slbc_sync2 u_sync_en (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .d_i(selftest_enable_pin_i),
    .q_o(en_pin_s)
  );
  slbc_sync2 u_sync_csel (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .d_i(selftest_clock_select_pin_i),
    .q_o(csel_pin_s)
  );

  // (RL1) either source enables
  wire test_en = en_pin_s | selftest_enable_cfg_i;
  // (RL13) gated by board strap, host keeps it high
  wire test_go = test_en & selftest_strap_high_i;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg pass_q;
  reg pass_d;
  reg failed_q;
  reg failed_d;
  reg [`SLBC_ERRCNT_BITS-1:0] cnt_q;
  reg [`SLBC_ERRCNT_BITS-1:0] cnt_d;
  reg req_q;
  reg csel_q;
  reg active_q;
  reg active_d;
  reg [`SLBC_ERRCNT_BITS-1:0] cnt_inc;
  wire cnt_full;
  wire frame_err;
  wire csel_d;
  wire [`SLBC_FRAME_BITS-1:0] bit_err;
  wire [`SLBC_FRAME_BITS:0] err_chain;
  genvar gi;

  // (RL6) per-bit compare against the all-zeros pattern
  // written as a chain for readability; synthesis folds it into a tree
  assign err_chain[0] = 1'b0;
  generate
    for (gi = 0; gi < `SLBC_FRAME_BITS; gi = gi + 1) begin : g_bit
      assign bit_err[gi] = frame_data_i[gi];
      assign err_chain[gi+1] = err_chain[gi] | bit_err[gi];
    end
  endgenerate

  // data between strobes is don't-care, so only a valid frame can be errored
  assign frame_err = frame_valid_i & err_chain[`SLBC_FRAME_BITS];

  // (RL14) saturate rather than wrap, so a long bad run never reads as clean
  assign cnt_full = (cnt_q == `SLBC_ERRCNT_MAX);
  always @* begin
    cnt_inc = cnt_q;
    if (!cnt_full) begin
      cnt_inc = cnt_q + 8'h01;
    end
  end

  // (RL2) either source may pick the oscillator at the far end
  // the choice is forwarded every cycle; the far end decides when to use it
  assign csel_d = csel_pin_s | selftest_clock_select_cfg_i;

  always @* begin
    state_d = state_q;
    pass_d = pass_q;
    failed_d = failed_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (test_go) begin
          // (RL9) new test clears old result
          state_d = ST_WAIT;
          failed_d = 1'b0;
          cnt_d = {`SLBC_ERRCNT_BITS{1'b0}};
          pass_d = 1'b0;
        end
      end
      ST_WAIT: begin
        if (!test_go) begin
          state_d = ST_DONE;
          pass_d = 1'b1;
        // (RL5) both ends in test and locked
        end else if (link_lock_i && remote_selftest_ack_i) begin
          state_d = ST_CHECK;
          pass_d = 1'b1;
        end
      end
      ST_CHECK: begin
        if (!test_go) begin
          // (RL8) stop and hold final result
          // a frame on the stopping edge still counts, or done would lose it
          state_d = ST_DONE;
          pass_d = ~failed_q & ~frame_err;
          if (frame_err) begin
            failed_d = 1'b1;
            cnt_d = cnt_inc;
          end
        end else begin
          // (RL6) one low cycle per errored frame
          pass_d = ~frame_err;
          if (frame_err) begin
            failed_d = 1'b1;
            // (RL14) saturating forward error count
            cnt_d = cnt_inc;
          end
        end
      end
      ST_DONE: begin
        // (RL9) hold until a new test
        pass_d = ~failed_q;
        if (test_go) begin
          state_d = ST_WAIT;
          failed_d = 1'b0;
          cnt_d = {`SLBC_ERRCNT_BITS{1'b0}};
          pass_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // registered copy of the decode keeps the mode outputs glitch free
    active_d = (state_d == ST_WAIT) | (state_d == ST_CHECK);
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      pass_q <= `SLBC_PASS_RST;
      failed_q <= 1'b0;
      cnt_q <= {`SLBC_ERRCNT_BITS{1'b0}};
      req_q <= 1'b0;
      csel_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pass_q <= pass_d;
      failed_q <= failed_d;
      cnt_q <= cnt_d;
      // (RL3) back-channel enable request
      req_q <= test_go;
      // (RL2) oscillator choice forwarded
      csel_q <= csel_d;
      active_q <= active_d;
    end
  end

  // (RL7) low for second half of the clock cycle only
  assign pass_o = pass_q | (state_q == ST_CHECK && clk_sys_i);
  // the clock itself shapes pass_o, so the pin must be timed as a clock path
  // trade-off: a true half-period pulse without a second clock edge
  assign bc_selftest_req_o = req_q;
  assign bc_use_internal_clock_o = csel_q;
  assign selftest_active_o = active_q;
  // (RL12) normal operation once enable drops
  assign link_normal_o = ~active_q;
  // (RL11) lock passed through unchanged
  assign lock_o = link_lock_i;
  assign fwd_err_count_o = cnt_q;
endmodule

// ---- hw/slbc_defines.vh ----
// shared constants for the serial link self-test checker
`ifndef SLBC_DEFINES_VH
`define SLBC_DEFINES_VH
`define SLBC_FRAME_BITS 35
`define SLBC_ERRCNT_BITS 8
`define SLBC_ERRCNT_MAX 8'hFF
`define SLBC_FWD_ERR_ADDR 8'h25
`define SLBC_OSC_MHZ 33
`define SLBC_CLK_NS 10
`define SLBC_PASS_RST 1'b1
`endif

// ---- hw/slbc_sync2.v ----
// two-flop level synchroniser
module slbc_sync2 (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire d_i,
  output wire q_o
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule
